// ===== sim/tb_ufx_serial_unit.sv
`timescale 1ns/1ps
module tb_ufx_serial_unit;
  logic mclk, rst_n, pwr, txe, rxe, c8, sl, lsb, inv, wr, odir, olat, idir, so, oe_n, bf, busy, done, rv, pe, fe, line;
  logic [1:0] ps;
  logic [3:0] sel;
  logic [7:0] div, td, rd, cap_d;
  logic cap_pe, cap_fe;
  int fails = 0, comparisons = 0, cyc = 0, done_cnt = 0, rv_cnt = 0;
  // sel 1, divisor 2: four mclk cycles per bit keeps frames short but leaves a mid-bit sample point
  ufx_remote #(.BIT_CYCLES(4)) rmt (.mclk(mclk), .line(line));
  ufx_serial_unit dut (.mclk(mclk), .rst_n(rst_n), .unit_power_bit(pwr), .tx_enable_bit(txe),
    .rx_enable_bit(rxe), .parity_select_hi(ps[1]), .parity_select_lo(ps[0]), .char_length_bit(c8),
    .stop_length_bit(sl), .bit_order_bit(lsb), .tx_invert_bit(inv), .clock_select(sel),
    .baud_divisor(div), .tx_write(wr), .tx_data(td), .out_pin_direction(odir), .out_pin_latch(olat),
    .in_pin_direction(idir), .serial_in_pin(line), .serial_out_pin(so), .serial_out_oe_n(oe_n),
    .tx_buf_full(bf), .tx_busy(busy), .tx_done_irq(done), .rx_data(rd), .rx_valid(rv),
    .rx_parity_err(pe), .rx_frame_err(fe));
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  // one-cycle pulses are caught here so a task never misses them
  always @(posedge mclk) begin
    cyc++;
    if (done === 1'h1) done_cnt++;
    if (rv === 1'h1) begin
      rv_cnt++;
      cap_d = rd;
      cap_pe = pe;
      cap_fe = fe;
    end
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // expected line bits before inversion: start, data, parity, stops
  task mk(input logic [7:0] d, input logic one_stop, output logic [11:0] fr, output int n);
    logic x;
    x = ^(c8 ? d : d & 8'h7f);
    fr = 12'hfff;
    fr[0] = 1'h0;
    n = 1;
    for (int i = 0; i < (c8 ? 8 : 7); i++) begin
      fr[n] = d[lsb ? i : (c8 ? 7 : 6) - i];
      n = n + 1;
    end
    if (ps != 2'h0) begin
      fr[n] = (ps == 2'h3) ? x : (ps == 2'h2) ? ~x : 1'h0;
      n = n + 1;
    end
    // stop bits are already ones from the fill above
    n = n + 1;
    if (sl && !one_stop) n = n + 1;
  endtask : mk
  // settings change only with both halves disabled, then enables return
  task cfg(input logic [1:0] p, input logic b8, input logic s2, input logic l, input logic v);
    @(posedge mclk) {txe, rxe} <= 2'h0;
    @(posedge mclk) {ps, c8, sl, lsb, inv} <= {p, b8, s2, l, v};
    @(posedge mclk) {txe, rxe} <= 2'h3;
    @(posedge mclk);
  endtask : cfg
  task tx_frame(input logic [7:0] d);
    logic [11:0] fr;
    int n, k, dc;
    mk(d, 1'h0, fr, n);
    dc = done_cnt;
    @(posedge mclk) {wr, td} <= {1'h1, d};
    @(posedge mclk) wr <= 1'h0;
    #1 check("buf_full", bf, 1'h1);
    k = 0;
    while (so === (1'h1 ^ inv) && k < 40) begin
      @(posedge mclk);
      #1 k++;
    end
    for (int i = 0; i < n; i++) begin
      repeat (i == 0 ? 2 : 4) @(posedge mclk);
      #1 check("tx_bit", so, fr[i] ^ inv);
    end
    check("done_early", done_cnt[7:0], dc[7:0]);
    repeat (3) @(posedge mclk);
    #1 check("done", done_cnt[7:0], dc[7:0] + 8'h1);
    check("busy_after", busy, 1'h0);
    check("idle_after", so, 1'h1 ^ inv);
  endtask : tx_frame
  task rx_frame(input logic [7:0] d, input logic bp, input logic bs);
    logic [11:0] fr;
    int n, c;
    mk(d, 1'h1, fr, n);
    if (bp) fr[n - 2] = ~fr[n - 2];
    if (bs) fr[n - 1] = 1'h0;
    c = rv_cnt;
    rmt.send(fr, n);
    repeat (4) @(posedge mclk);
    #1 check("rx_count", rv_cnt[7:0], c[7:0] + 8'h1);
    check("rx_data", cap_d, c8 ? d : d & 8'h7f);
    check("rx_parity", cap_pe, bp & ps[1]);
    check("rx_frame", cap_fe, bs);
  endtask : rx_frame
  task t_pins();
    @(posedge mclk) {olat, odir} <= 2'h0;
    #1 @(posedge mclk) #1 check("port_pin", so, 1'h0);
    check("port_oe", oe_n, 1'h0);
    @(posedge mclk) pwr <= 1'h1;
    {olat, odir} <= 2'h2;
    repeat (2) @(posedge mclk);
    #1 check("idle_high", so, 1'h1);
    $display("test pins done");
  endtask : t_pins
  task t_even();
    cfg(2'h3, 1'h1, 1'h0, 1'h1, 1'h0);
    tx_frame(8'h55);
    rx_frame(8'h55, 1'h0, 1'h0);
    rx_frame(8'h55, 1'h1, 1'h0);
    $display("test even done");
  endtask : t_even
  task t_msb_inv();
    cfg(2'h3, 1'h1, 1'h0, 1'h0, 1'h1);
    tx_frame(8'h55);
    $display("test msb_inv done");
  endtask : t_msb_inv
  task t_odd7();
    cfg(2'h2, 1'h0, 1'h1, 1'h1, 1'h0);
    tx_frame(8'h36);
    rx_frame(8'h36, 1'h1, 1'h0);
    $display("test odd7 done");
  endtask : t_odd7
  task t_zero_none();
    cfg(2'h1, 1'h1, 1'h0, 1'h1, 1'h0);
    tx_frame(8'ha5);
    rx_frame(8'ha5, 1'h1, 1'h0);
    cfg(2'h0, 1'h1, 1'h0, 1'h1, 1'h0);
    tx_frame(8'h87);
    rx_frame(8'h87, 1'h0, 1'h1);
    $display("test zero_none done");
  endtask : t_zero_none
  task t_enable();
    @(posedge mclk) txe <= 1'h0;
    @(posedge mclk) {wr, td} <= 9'h1ff;
    @(posedge mclk) wr <= 1'h0;
    repeat (12) @(posedge mclk);
    #1 check("write_refused", busy | bf, 1'h0);
    @(posedge mclk) txe <= 1'h1;
    @(posedge mclk) {wr, td} <= 9'h1f0;
    @(posedge mclk) wr <= 1'h0;
    repeat (8) @(posedge mclk);
    #1 check("busy_mid", busy, 1'h1);
    @(posedge mclk) txe <= 1'h0;
    repeat (3) @(posedge mclk);
    #1 check("tx_reset", {busy, bf, so}, 3'h1);
    @(posedge mclk) txe <= 1'h1;
    $display("test enable done");
  endtask : t_enable
  task t_duplex();
    fork
      tx_frame(8'hc3);
      rx_frame(8'h3c, 1'h0, 1'h0);
    join
    $display("test duplex done");
  endtask : t_duplex
  initial begin
    {rst_n, pwr, txe, rxe, ps, c8, sl, lsb, inv, wr, td} = 19'h0;
    {odir, olat, idir} = 3'h7;
    sel = 4'h1;
    div = 8'h02;
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    t_pins();
    t_even();
    t_msb_inv();
    t_odd7();
    t_zero_none();
    t_enable();
    t_duplex();
    tally_and_finish();
  end
endmodule : tb_ufx_serial_unit

// ===== sim/ufx_remote.sv
`timescale 1ns/1ps
// far-side transceiver: drives the receive line one frame at a time
module ufx_remote #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic mclk,
  output logic line
);
  initial line = 1'h1;
  // lowest index goes first; the line falls back to its pulled-up idle level after the frame
  task send(input logic [11:0] fr, input int n);
    begin
      @(posedge mclk);
      for (int i = 0; i < n; i++) begin
        line <= fr[i];
        repeat (BIT_CYCLES) @(posedge mclk);
      end
      line <= 1'h1;
    end
  endtask : send
endmodule : ufx_remote

// ===== src/ufx_baud.sv
`timescale 1ns/1ps
`include "ufx_defines.svh"
// bit-rate enable: mclk / 2^clk_sel gives the base rate, divisor base ticks make one bit
module ufx_baud #(
  parameter int PRE_W = 11
) (
  input wire logic mclk,
  input wire logic run,
  input wire logic restart,
  ufx_cfg_if.snk cfg,
  output logic tick,
  output logic mid
);
  if (PRE_W < 11) begin : g_bad_width
    $error("ufx_baud: PRE_W must hold a prescale of 2^10");
  end

  logic [PRE_W-1:0] pre_cnt_reg;
  logic [7:0] div_cnt_reg;
  logic [3:0] sel;
  logic [PRE_W-1:0] pre_lim;
  logic [7:0] div_eff;
  logic base;

  // out-of-range selects clamp to the slowest prescale rather than wrapping
  assign sel = (cfg.clk_sel > `UFX_CLK_SEL_MAX) ? `UFX_CLK_SEL_MAX : cfg.clk_sel;
  assign pre_lim = PRE_W'((`UFX_PRE_ONE << sel) - `UFX_PRE_ONE);
  assign div_eff = (cfg.divisor < `UFX_DIV_MIN) ? `UFX_DIV_MIN : cfg.divisor;
  assign base = (pre_cnt_reg == pre_lim);
  assign tick = base && (div_cnt_reg == div_eff - `UFX_DIV_MIN);
  // mid point is the end of base tick div/2, so a divisor of 2 samples half way through the bit;
  // a divisor of 1 has no base tick inside the bit and then samples at the bit's end
  assign mid = base && (div_cnt_reg == ((div_eff - `UFX_DIV_MIN) >> 1));

  // prescaler, restarted so a bit always starts on a full period
  always_ff @(posedge mclk) begin
    if (!run || restart || base) begin
      pre_cnt_reg <= '0;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 1'b1;
    end
  end

  // divisor counter
  always_ff @(posedge mclk) begin
    if (!run || restart || tick) begin
      div_cnt_reg <= 8'h00;
    end else if (base) begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end
endmodule : ufx_baud

// ===== src/ufx_cfg_if.sv
`timescale 1ns/1ps
// frame and rate settings shared by the transmitter, receiver and baud generators
interface ufx_cfg_if;
  logic [3:0] clk_sel;
  logic [7:0] divisor;
  logic char8;
  logic lsb_first;
  ufx_pkg::ufx_parity_t parity;
  modport src (output clk_sel, output divisor, output char8, output lsb_first, output parity);
  modport snk (input clk_sel, input divisor, input char8, input lsb_first, input parity);
endinterface : ufx_cfg_if

// ===== src/ufx_defines.svh
`ifndef UFX_DEFINES_SVH
`define UFX_DEFINES_SVH

// parity select field codes {parity_select_hi, parity_select_lo}
`define UFX_PS_NONE 2'b00
`define UFX_PS_ZERO 2'b01
`define UFX_PS_ODD 2'b10
`define UFX_PS_EVEN 2'b11

// character length: index of the last character bit and the data mask
`define UFX_LAST_BIT_8 3'h7
`define UFX_LAST_BIT_7 3'h6
`define UFX_MASK_8 8'hff
`define UFX_MASK_7 8'h7f

// baud generator limits
`define UFX_CLK_SEL_MAX 4'ha
`define UFX_DIV_MIN 8'h01
`define UFX_PRE_ONE 11'h001

// line levels
`define UFX_IDLE_LEVEL 1'b1
`define UFX_START_LEVEL 1'b0
`define UFX_STOP_LEVEL 1'b1
`define UFX_ZERO_PARITY 1'b0

`endif

// ===== src/ufx_pkg.sv
package ufx_pkg;

  typedef enum logic [1:0] {UFX_PAR_NONE, UFX_PAR_ZERO, UFX_PAR_ODD, UFX_PAR_EVEN} ufx_parity_t;

  typedef enum logic [2:0] {UFX_ST_IDLE, UFX_ST_START, UFX_ST_DATA, UFX_ST_PARITY, UFX_ST_STOP} ufx_state_t;

endpackage : ufx_pkg

// ===== src/ufx_rx.sv
`timescale 1ns/1ps
`include "ufx_defines.svh"
// receiver: samples each bit at mid period, always one stop bit
module ufx_rx (
  input wire logic mclk,
  input wire logic run,
  input wire logic line,
  input wire logic mid,
  ufx_cfg_if.snk cfg,
  output logic restart,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_parity_err,
  output logic rx_frame_err
);
  ufx_pkg::ufx_state_t st_reg;
  logic [2:0] cnt_reg;
  logic [7:0] sh_reg;
  logic par_reg;
  logic [2:0] last;
  logic [2:0] idx;
  logic perr;

  assign last = cfg.char8 ? `UFX_LAST_BIT_8 : `UFX_LAST_BIT_7;
  assign idx = cfg.lsb_first ? cnt_reg : last - cnt_reg; // R2
  assign restart = (st_reg == ufx_pkg::UFX_ST_IDLE) && !line;
  // even flags an odd count, odd flags an even count, zero and none never flag
  always_comb begin
    case (cfg.parity)
      ufx_pkg::UFX_PAR_EVEN: perr = ^sh_reg ^ par_reg; // R5
      ufx_pkg::UFX_PAR_ODD: perr = ~(^sh_reg ^ par_reg); // R7
      default: perr = 1'b0; // R8 R9
    endcase
  end

  // frame sequencer, reset by the receive enable
  always_ff @(posedge mclk) begin
    if (!run) begin
      st_reg <= ufx_pkg::UFX_ST_IDLE;
    end else begin
      case (st_reg)
        ufx_pkg::UFX_ST_IDLE: if (restart) st_reg <= ufx_pkg::UFX_ST_START;
        ufx_pkg::UFX_ST_START: if (mid) st_reg <= line ? ufx_pkg::UFX_ST_IDLE : ufx_pkg::UFX_ST_DATA;
        ufx_pkg::UFX_ST_DATA: begin
          if (mid && cnt_reg == last) begin
            st_reg <= (cfg.parity == ufx_pkg::UFX_PAR_NONE) ? ufx_pkg::UFX_ST_STOP : ufx_pkg::UFX_ST_PARITY; // R9
          end
        end
        ufx_pkg::UFX_ST_PARITY: if (mid) st_reg <= ufx_pkg::UFX_ST_STOP;
        default: if (mid) st_reg <= ufx_pkg::UFX_ST_IDLE; // R22
      endcase
    end
  end

  // bit capture
  always_ff @(posedge mclk) begin
    if (!run || restart) begin
      cnt_reg <= 3'h0;
      sh_reg <= 8'h00;
      par_reg <= 1'b0;
    end else if (mid && st_reg == ufx_pkg::UFX_ST_DATA) begin
      sh_reg[idx] <= line;
      cnt_reg <= cnt_reg + 3'h1;
    end else if (mid && st_reg == ufx_pkg::UFX_ST_PARITY) begin
      par_reg <= line;
    end
  end

  // result and status, updated once per frame at the stop sample
  always_ff @(posedge mclk) begin
    if (!run) begin
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_parity_err <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_valid <= mid && st_reg == ufx_pkg::UFX_ST_STOP;
      if (mid && st_reg == ufx_pkg::UFX_ST_STOP) begin
        rx_data <= sh_reg;
        rx_parity_err <= perr;
        rx_frame_err <= !line;
      end
    end
  end

  AST_RX_EVEN: assert property (@(posedge mclk) disable iff (!run)
    (mid && st_reg == ufx_pkg::UFX_ST_STOP && cfg.parity == ufx_pkg::UFX_PAR_EVEN)
      |=> rx_parity_err == (^rx_data ^ $past(par_reg))) else $error("even parity check wrong"); // R5
  AST_RX_ODD: assert property (@(posedge mclk) disable iff (!run)
    (mid && st_reg == ufx_pkg::UFX_ST_STOP && cfg.parity == ufx_pkg::UFX_PAR_ODD)
      |=> rx_parity_err == !(^rx_data ^ $past(par_reg))) else $error("odd parity check wrong"); // R7
  AST_RX_NOPAR: assert property (@(posedge mclk) disable iff (!run)
    (rx_valid && !cfg.parity[1]) |-> !rx_parity_err) else $error("parity error without checking"); // R8
  AST_RX_ONE_STOP: assert property (@(posedge mclk) disable iff (!run)
    (mid && st_reg == ufx_pkg::UFX_ST_STOP) |=> st_reg == ufx_pkg::UFX_ST_IDLE && rx_valid)
    else $error("receiver waited for a second stop bit"); // R22
  COV_RX_FRAME: cover property (@(posedge mclk) disable iff (!run) rx_valid && !rx_frame_err);
endmodule : ufx_rx

// ===== src/ufx_serial_unit.sv
`timescale 1ns/1ps
`include "ufx_defines.svh"
// What the document requires of this block and its software
// R1: start, 7/8 data, optional parity, 1/2 stops
// R2: bit order bit picks LSB or MSB first
// R3: invert bit inverts the transmit line
// R4: even parity: bit set on odd ones
// R5: even parity receive flags odd count
// R6: odd parity: bit set on even ones
// R7: odd parity receive flags even count
// R8: zero parity sends 0, never flags
// R9: no parity: no bit, never flags
// R10: software keeps parity select zero for LIN
// R11: powered transmit line idles high
// R12: powered, enabled, buffer write starts frame
// R13: start, parity, stop bits inserted by hardware
// R14: buffer moves to shift register, shifted out
// R15: done pulse after final stop bit (code: pulse in the last mclk cycle of the pin's final stop bit)
// R16: idle high until next buffer write
// R17: power off: pins behave as port pins
// R18: software follows the documented setup order
// R19: one byte per frame, full duplex
// R20: power off: line high, unit reset
// R21: enable bits reset their own half
// R22: receiver always uses one stop bit
// R23: each bit lasts one baud period
// R24: software changes order/invert only when disabled
module ufx_serial_unit (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic unit_power_bit,
  input wire logic tx_enable_bit,
  input wire logic rx_enable_bit,
  input wire logic parity_select_hi,
  input wire logic parity_select_lo,
  input wire logic char_length_bit,
  input wire logic stop_length_bit,
  input wire logic bit_order_bit,
  input wire logic tx_invert_bit,
  input wire logic [3:0] clock_select,
  input wire logic [7:0] baud_divisor,
  input wire logic tx_write,
  input wire logic [7:0] tx_data,
  input wire logic out_pin_direction,
  input wire logic out_pin_latch,
  input wire logic in_pin_direction,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  output logic tx_buf_full,
  output logic tx_busy,
  output logic tx_done_irq,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_parity_err,
  output logic rx_frame_err
);
  logic unit_run;
  logic tx_run;
  logic rx_run;
  logic rx_line;
  logic tx_tick;
  logic rx_mid;
  logic rx_restart;
  ufx_pkg::ufx_parity_t parity_mode;
  ufx_cfg_if cfg ();

  // power off holds both halves and their bit timers in reset; the enables reset only their own half
  assign unit_run = rst_n && unit_power_bit; // R20
  assign tx_run = unit_run && tx_enable_bit; // R21
  assign rx_run = unit_run && rx_enable_bit; // R21

  // receive input reads high unless powered and the pin is an input
  assign rx_line = (unit_power_bit && in_pin_direction) ? serial_in_pin : `UFX_IDLE_LEVEL; // R20 R17

  // parity field decode
  always_comb begin
    case ({parity_select_hi, parity_select_lo})
      `UFX_PS_ZERO: parity_mode = ufx_pkg::UFX_PAR_ZERO;
      `UFX_PS_ODD: parity_mode = ufx_pkg::UFX_PAR_ODD;
      `UFX_PS_EVEN: parity_mode = ufx_pkg::UFX_PAR_EVEN;
      default: parity_mode = ufx_pkg::UFX_PAR_NONE;
    endcase
  end

  // shared frame settings
  assign cfg.clk_sel = clock_select;
  assign cfg.divisor = baud_divisor;
  assign cfg.char8 = char_length_bit;
  assign cfg.lsb_first = bit_order_bit;
  assign cfg.parity = parity_mode;

  // ---------------- transmitter ----------------
  ufx_pkg::ufx_state_t tx_state_reg;
  logic [7:0] tx_buffer_reg;
  logic tx_buf_full_reg;
  logic [7:0] tx_shift_reg;
  logic [2:0] tx_bit_cnt_reg;
  logic tx_out_reg;
  logic tx_oe_n_reg;
  logic tx_done_reg;
  logic tx_load;
  logic [2:0] tx_last;
  logic [2:0] tx_idx;
  logic [7:0] tx_mask;
  logic tx_ones_odd;
  logic tx_par_bit;
  logic tx_data_end;
  logic tx_stop_end;
  logic tx_line_now;

  // the buffer empties into the shift register only between frames
  assign tx_load = tx_buf_full_reg && (tx_state_reg == ufx_pkg::UFX_ST_IDLE); // R14
  assign tx_last = char_length_bit ? `UFX_LAST_BIT_8 : `UFX_LAST_BIT_7; // R1
  assign tx_mask = char_length_bit ? `UFX_MASK_8 : `UFX_MASK_7;
  assign tx_idx = bit_order_bit ? tx_bit_cnt_reg : tx_last - tx_bit_cnt_reg; // R2
  assign tx_ones_odd = ^(tx_shift_reg & tx_mask);
  assign tx_data_end = tx_tick && (tx_state_reg == ufx_pkg::UFX_ST_DATA) && (tx_bit_cnt_reg == tx_last);
  // second stop bit only when the stop length bit asks for it
  assign tx_stop_end = tx_tick && (tx_state_reg == ufx_pkg::UFX_ST_STOP) &&
                       (tx_bit_cnt_reg == {2'b00, stop_length_bit}); // R1

  // parity value chosen from the character's count of ones
  always_comb begin
    case (parity_mode)
      ufx_pkg::UFX_PAR_EVEN: tx_par_bit = tx_ones_odd; // R4
      ufx_pkg::UFX_PAR_ODD: tx_par_bit = !tx_ones_odd; // R6
      default: tx_par_bit = `UFX_ZERO_PARITY; // R8
    endcase
  end

  // level the frame wants on the line right now, before inversion
  always_comb begin
    case (tx_state_reg)
      ufx_pkg::UFX_ST_START: tx_line_now = `UFX_START_LEVEL; // R13
      ufx_pkg::UFX_ST_DATA: tx_line_now = tx_shift_reg[tx_idx]; // R14
      ufx_pkg::UFX_ST_PARITY: tx_line_now = tx_par_bit; // R13
      ufx_pkg::UFX_ST_STOP: tx_line_now = `UFX_STOP_LEVEL; // R13
      default: tx_line_now = `UFX_IDLE_LEVEL; // R11 R16
    endcase
  end

  // transmit buffer; a write while full overwrites, as software must poll first
  always_ff @(posedge mclk) begin
    if (!unit_run) begin
      tx_buffer_reg <= 8'h00;
    end else if (tx_run && tx_write) begin
      tx_buffer_reg <= tx_data;
    end
  end

  // buffer full flag: a write in the load cycle keeps it set
  always_ff @(posedge mclk) begin
    if (!tx_run) begin
      tx_buf_full_reg <= 1'b0;
    end else if (tx_write) begin
      tx_buf_full_reg <= 1'b1; // R12
    end else if (tx_load) begin
      tx_buf_full_reg <= 1'b0;
    end
  end

  // shift register copy of the character
  always_ff @(posedge mclk) begin
    if (!unit_run) begin
      tx_shift_reg <= 8'h00;
    end else if (tx_load) begin
      tx_shift_reg <= tx_buffer_reg; // R14
    end
  end

  // frame sequencer; stays idle until the buffer holds the next byte
  always_ff @(posedge mclk) begin
    if (!tx_run) begin
      tx_state_reg <= ufx_pkg::UFX_ST_IDLE; // R21
    end else begin
      case (tx_state_reg)
        ufx_pkg::UFX_ST_IDLE: if (tx_load) tx_state_reg <= ufx_pkg::UFX_ST_START; // R12 R16
        ufx_pkg::UFX_ST_START: if (tx_tick) tx_state_reg <= ufx_pkg::UFX_ST_DATA; // R23
        ufx_pkg::UFX_ST_DATA: begin
          if (tx_data_end) begin
            tx_state_reg <= (parity_mode == ufx_pkg::UFX_PAR_NONE) ? ufx_pkg::UFX_ST_STOP :
                            ufx_pkg::UFX_ST_PARITY; // R9 R23
          end
        end
        ufx_pkg::UFX_ST_PARITY: if (tx_tick) tx_state_reg <= ufx_pkg::UFX_ST_STOP;
        default: if (tx_stop_end) tx_state_reg <= ufx_pkg::UFX_ST_IDLE;
      endcase
    end
  end

  // counts character bits, then stop bits; cleared on every state change
  always_ff @(posedge mclk) begin
    if (!tx_run || tx_load) begin
      tx_bit_cnt_reg <= 3'h0;
    end else if (tx_tick) begin
      if (tx_data_end || tx_stop_end || tx_state_reg == ufx_pkg::UFX_ST_START ||
          tx_state_reg == ufx_pkg::UFX_ST_PARITY) begin
        tx_bit_cnt_reg <= 3'h0;
      end else begin
        tx_bit_cnt_reg <= tx_bit_cnt_reg + 3'h1;
      end
    end
  end

  // pin driver: unit data when powered, port latch otherwise; direction from the port
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_out_reg <= `UFX_IDLE_LEVEL;
      tx_oe_n_reg <= 1'b1;
    end else begin
      tx_out_reg <= unit_power_bit ? (tx_line_now ^ tx_invert_bit) : out_pin_latch; // R3 R17 R20
      tx_oe_n_reg <= out_pin_direction; // R17
    end
  end

  // completion pulse covers the last mclk cycle of the pin's final stop bit, one cycle before the pin returns to idle
  always_ff @(posedge mclk) begin
    if (!tx_run) begin
      tx_done_reg <= 1'b0;
    end else begin
      tx_done_reg <= tx_stop_end; // R15
    end
  end

  assign serial_out_pin = tx_out_reg;
  assign serial_out_oe_n = tx_oe_n_reg;
  assign tx_buf_full = tx_buf_full_reg;
  assign tx_busy = (tx_state_reg != ufx_pkg::UFX_ST_IDLE);
  assign tx_done_irq = tx_done_reg;

  // separate bit timers keep the two directions independent
  ufx_baud u_tx_baud (
    .mclk(mclk),
    .run(tx_run),
    .restart(tx_load),
    .cfg(cfg.snk),
    .tick(tx_tick),
    .mid()
  ); // R19 R23

  ufx_baud u_rx_baud (
    .mclk(mclk),
    .run(rx_run),
    .restart(rx_restart),
    .cfg(cfg.snk),
    .tick(),
    .mid(rx_mid)
  );

  ufx_rx u_rx (
    .mclk(mclk),
    .run(rx_run),
    .line(rx_line),
    .mid(rx_mid),
    .cfg(cfg.snk),
    .restart(rx_restart),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_parity_err(rx_parity_err),
    .rx_frame_err(rx_frame_err)
  ); // R19

  // ---------------- checks ----------------
  AST_IDLE_HIGH: assert property (@(posedge mclk) disable iff (!rst_n)
    (unit_power_bit && !tx_invert_bit && tx_state_reg == ufx_pkg::UFX_ST_IDLE) |=> serial_out_pin)
    else $error("idle line not high"); // R11
  AST_INVERT_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
    (unit_power_bit && tx_invert_bit && tx_state_reg == ufx_pkg::UFX_ST_IDLE) |=> !serial_out_pin)
    else $error("inverted idle line not low"); // R3
  AST_POWER_OFF_PORT: assert property (@(posedge mclk) disable iff (!rst_n)
    !unit_power_bit |=> serial_out_pin == $past(out_pin_latch) && tx_state_reg == ufx_pkg::UFX_ST_IDLE)
    else $error("pin not released to port with power off"); // R20
  AST_START_BIT: assert property (@(posedge mclk) disable iff (!tx_run)
    (tx_load && !tx_invert_bit) ##1 (tx_run && !tx_invert_bit) |=> !serial_out_pin)
    else $error("no start bit after load"); // R13
  AST_LOAD_COPY: assert property (@(posedge mclk) disable iff (!tx_run)
    tx_load |=> tx_shift_reg == $past(tx_buffer_reg) && tx_state_reg == ufx_pkg::UFX_ST_START)
    else $error("buffer not moved to shift register"); // R14
  AST_PAR_EVEN: assert property (@(posedge mclk) disable iff (!tx_run)
    (tx_state_reg == ufx_pkg::UFX_ST_PARITY && parity_mode == ufx_pkg::UFX_PAR_EVEN)
      |-> tx_line_now == ^(tx_shift_reg & tx_mask)) else $error("even parity bit wrong"); // R4
  AST_PAR_ODD: assert property (@(posedge mclk) disable iff (!tx_run)
    (tx_state_reg == ufx_pkg::UFX_ST_PARITY && parity_mode == ufx_pkg::UFX_PAR_ODD)
      |-> tx_line_now != ^(tx_shift_reg & tx_mask)) else $error("odd parity bit wrong"); // R6
  AST_PAR_ZERO: assert property (@(posedge mclk) disable iff (!tx_run)
    (tx_state_reg == ufx_pkg::UFX_ST_PARITY && parity_mode == ufx_pkg::UFX_PAR_ZERO) |-> !tx_line_now)
    else $error("zero parity bit not zero"); // R8
  AST_NO_PARITY: assert property (@(posedge mclk) disable iff (!tx_run)
    (tx_data_end && parity_mode == ufx_pkg::UFX_PAR_NONE) |=> tx_state_reg == ufx_pkg::UFX_ST_STOP)
    else $error("parity slot sent with no parity"); // R9
  AST_LSB_ORDER: assert property (@(posedge mclk) disable iff (!tx_run)
    (tx_state_reg == ufx_pkg::UFX_ST_DATA && bit_order_bit) |-> tx_line_now == tx_shift_reg[tx_bit_cnt_reg])
    else $error("lsb-first order wrong"); // R2
  AST_DONE_PULSE: assert property (@(posedge mclk) disable iff (!tx_run)
    tx_done_irq |-> $past(tx_state_reg) == ufx_pkg::UFX_ST_STOP && $past(tx_tick) ##1 !tx_done_irq)
    else $error("done pulse not tied to last stop bit"); // R15
  AST_TXE_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
    !tx_enable_bit |=> tx_state_reg == ufx_pkg::UFX_ST_IDLE && !tx_buf_full)
    else $error("transmit half not reset by enable"); // R21
  AST_BIT_HOLD: assert property (@(posedge mclk) disable iff (!tx_run)
    (tx_state_reg != ufx_pkg::UFX_ST_IDLE && !tx_tick) |=> $stable(tx_state_reg))
    else $error("bit ended without a baud tick"); // R23
  AST_STAY_IDLE: assert property (@(posedge mclk) disable iff (!tx_run)
    (tx_state_reg == ufx_pkg::UFX_ST_IDLE && !tx_buf_full_reg && !tx_write) |=>
      tx_state_reg == ufx_pkg::UFX_ST_IDLE) else $error("frame started without a write"); // R16 R12
  AST_FRAME_DUPLEX: assert property (@(posedge mclk) disable iff (!rx_run)
    (tx_load && !rx_mid && !rx_restart) |=> $stable(u_rx.st_reg))
    else $error("receiver disturbed by transmitter"); // R19

  COV_EVEN_FRAME: cover property (@(posedge mclk) disable iff (!tx_run)
    tx_done_irq && parity_mode == ufx_pkg::UFX_PAR_EVEN);
  COV_TWO_STOP: cover property (@(posedge mclk) disable iff (!tx_run) tx_stop_end && stop_length_bit);
  COV_BACK_TO_BACK: cover property (@(posedge mclk) disable iff (!tx_run) tx_done_irq ##1 tx_load);
  COV_MSB_7BIT: cover property (@(posedge mclk) disable iff (!tx_run)
    tx_data_end && !bit_order_bit && !char_length_bit);
endmodule : ufx_serial_unit
